// file: hw/sacp_adc_ctrl.v
// Function
// R1 - Eight-bit successive approximation, 256 codes
// R2 - Channel from ctrl_low[1:0] plus ctrl_high[0]
// R3 - ctrl_high[0] picks inputs 0-3 or 4-7
// R4 - Finished conversion stores result register
// R5 - Writing ctrl_low bit 3 starts conversion
// R6 - Reading ctrl_low bit 3 shows done
// R7 - Result nibble chosen by index LSB
// R8 - Clock source fixed: pin or prescaler
// R9 - Internal clock is machine clock / 2^n
// R10 - Conversion clock at most 225 kHz
// R11 - External clock runs before start
// R12 - Twelve-bit prescaler on machine cycle clock
// R13 - Prescaler feeds timers, serial, converter, pin
// R14 - Prescaler halt bit stops all outputs
// R15 - Clearing halt restarts counter from zero
`include "sacp_defs.vh"

module sacp_adc_ctrl #(
  parameter USE_EXT_CLK = 0,  // Mask choice: 1 takes the conversion clock pin
  parameter DIV_SEL     = 0   // Mask choice: prescaler tap, divide by 2^(DIV_SEL+1)
) (
  input  wire        i_sys_clk,           // System clock, oscillator rate
  input  wire        i_rst_b,             // Asynchronous reset, active low
  input  wire        i_per_wr,            // Peripheral write strobe, one cycle
  input  wire        i_per_rd,            // Peripheral read strobe
  input  wire [3:0]  i_per_addr,          // Peripheral register index
  input  wire [3:0]  i_per_wdata,         // Peripheral write nibble
  input  wire        i_index_lsb,         // Index register LSB for result nibble
  output reg  [3:0]  o_per_rdata,         // Peripheral read nibble
  input  wire        i_conv_clock_pin,    // External conversion clock pin
  input  wire        i_cmp_above,         // Comparator: input at or above trial
  output reg  [7:0]  o_dac_code,          // Trial code to resistor network
  output reg  [2:0]  o_analog_sel,        // Selected analog input
  output reg         o_sample,            // Conversion active
  output wire [11:0] o_pre_taps,          // Prescaler taps to timers and serial
  output wire        o_clock_output_pin   // Prescaler tap to output pin
);
  //////////////////////////////////////////////////////////////////////////////
  // Registers
  reg [3:0]  ctrl_low_q;   // Channel bits; start bit position always stored as zero
  reg [3:0]  ctrl_high_q;  // Bank select in bit 0
  reg [7:0]  result_q;     // Last converted value
  reg        halt_q;       // Prescaler halt, bit 2 of timer1/prescaler control
  reg        busy_q;       // Conversion in progress
  reg        done_q;       // End of conversion flag
  reg [2:0]  mach_cnt_q;   // Oscillator to machine cycle divider
  reg [11:0] pre_q;        // Prescaler count
  reg [2:0]  bit_q;        // Current trial bit
  reg [7:0]  sar_q;        // Approximation register
  reg        cclk_q;       // Previous conversion clock level

  wire       mach_tick;    // One pulse per machine cycle
  wire       pin_sync;     // Synchronised conversion clock pin
  wire       conv_clk;     // Chosen conversion clock level
  wire       conv_tick;    // Rising edge of conversion clock
  wire       wr_lo;        // Write to control low
  wire       start;        // Start of conversion request
  wire       wr_hi;        // Write to control high
  wire [1:0] chan_d;       // Channel bits as they stand after this edge
  wire       bank_d;       // Bank bit as it stands after this edge

  // Register select compare, used by both strobes
  function sel;
    input [3:0] a;
    input [3:0] r;
    begin
      sel = (a == r);
    end
  endfunction

  sacp_sync u_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst_b   (i_rst_b),
    .i_async   (i_conv_clock_pin),
    .o_sync    (pin_sync)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Machine cycle and prescaler
  // Compared at the counter's own width so no bits are lost
  assign mach_tick = (mach_cnt_q == `SACP_MACH_DIV - 3'h1);  // R9

  // Machine cycle is the oscillator divided by six
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mach_cnt_q <= 3'h0;
    end else if (mach_tick) begin
      mach_cnt_q <= 3'h0;
    end else begin
      mach_cnt_q <= mach_cnt_q + 3'h1;
    end
  end

  // Halt bit lives in the timer1/prescaler control register
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      halt_q <= 1'b0;
    end else if (i_per_wr && sel(i_per_addr, `SACP_REG_TMR1_PRE)) begin
      halt_q <= i_per_wdata[`SACP_PRE_HALT_BIT];
    end
  end

  // Counter held at zero while halted so restart begins from zero
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pre_q <= 12'h000;
    end else if (halt_q) begin
      pre_q <= 12'h000;  // R14 R15
    end else if (mach_tick) begin
      pre_q <= pre_q + 12'h001;  // R12
    end
  end

  // Taps: bit n divides by 2^(n+1); all low while halted
  assign o_pre_taps         = pre_q;  // R13
  assign o_clock_output_pin = pre_q[DIV_SEL];  // R13 R14

  //////////////////////////////////////////////////////////////////////////////
  // Conversion clock selection
  // Fixed at build; limit of 225 kHz is the system's job
  assign conv_clk  = (USE_EXT_CLK != 0) ? pin_sync : pre_q[DIV_SEL];  // R8 R9
  assign conv_tick = conv_clk & ~cclk_q;

  // Edge detect on the chosen clock level
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cclk_q <= 1'b0;
    end else begin
      cclk_q <= conv_clk;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control registers
  assign wr_lo = i_per_wr && sel(i_per_addr, `SACP_REG_CTRL_LO);
  assign start = wr_lo && i_per_wdata[`SACP_CTRL_START_BIT];  // R5
  assign wr_hi = i_per_wr && sel(i_per_addr, `SACP_REG_CTRL_HI);

  // Channel bits stored; start bit is an action, not stored
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl_low_q  <= `SACP_CTRL_LO_RST;
      ctrl_high_q <= `SACP_CTRL_HI_RST;
    end else begin
      if (wr_lo) begin
        ctrl_low_q <= {1'b0, i_per_wdata[2:0]};
      end
      if (wr_hi) begin
        ctrl_high_q <= i_per_wdata;
      end
    end
  end

  // Input mux select: bank bit over the two channel bits.
  // Taken from the write itself rather than the stored copy, so a start
  // that also changes channel compares the new input on its first trial.
  assign chan_d = wr_lo ? i_per_wdata[1:0] : ctrl_low_q[1:0];
  assign bank_d = wr_hi ? i_per_wdata[0] : ctrl_high_q[0];

  // Mux select register, loaded together with the control registers
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_analog_sel <= 3'h0;
    end else begin
      o_analog_sel <= {bank_d, chan_d};  // R2 R3
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Successive approximation sequencer
  // One trial bit per conversion clock edge, MSB first
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      busy_q     <= 1'b0;
      done_q     <= 1'b0;
      bit_q      <= 3'h7;
      sar_q      <= 8'h00;
      result_q   <= `SACP_RESULT_RST;
      o_dac_code <= 8'h00;
      o_sample   <= 1'b0;
    end else if (start) begin
      // A new start aborts any running conversion
      busy_q     <= 1'b1;
      done_q     <= 1'b0;
      bit_q      <= 3'h7;
      sar_q      <= 8'h80;
      o_dac_code <= 8'h80;
      o_sample   <= 1'b1;
    end else if (busy_q && conv_tick) begin
      // Keep trial bit if input is at or above, then try next
      if (bit_q == 3'h0) begin
        busy_q   <= 1'b0;
        done_q   <= 1'b1;  // R6
        o_sample <= 1'b0;
        result_q <= i_cmp_above ? sar_q : (sar_q & 8'hfe);  // R1 R4
      end else begin
        sar_q      <= (i_cmp_above ? sar_q : (sar_q & ~(8'h01 << bit_q)))
                      | (8'h01 << (bit_q - 3'h1));  // R1
        o_dac_code <= (i_cmp_above ? sar_q : (sar_q & ~(8'h01 << bit_q)))
                      | (8'h01 << (bit_q - 3'h1));
        bit_q      <= bit_q - 3'h1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read path, registered nibble
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_per_rdata <= 4'h0;
    end else if (i_per_rd) begin
      if (sel(i_per_addr, `SACP_REG_CTRL_LO)) begin
        o_per_rdata <= {done_q, ctrl_low_q[2:0]};  // R6
      end else if (sel(i_per_addr, `SACP_REG_RESULT)) begin
        o_per_rdata <= i_index_lsb ? result_q[7:4] : result_q[3:0];  // R7
      end else if (sel(i_per_addr, `SACP_REG_CTRL_HI)) begin
        o_per_rdata <= ctrl_high_q;
      end else if (sel(i_per_addr, `SACP_REG_TMR1_PRE)) begin
        o_per_rdata <= {1'b0, halt_q, 2'b00};
      end else begin
        o_per_rdata <= 4'h0;  // Unmapped index reads zero
      end
    end
  end
endmodule // sacp_adc_ctrl

// file: hw/sacp_defs.vh
`ifndef SACP_DEFS_VH
`define SACP_DEFS_VH
// Peripheral register indices on the 4-bit peripheral port
`define SACP_REG_CTRL_LO   4'h7
`define SACP_REG_RESULT    4'h8
`define SACP_REG_CTRL_HI   4'ha
`define SACP_REG_TMR1_PRE  4'h3
// Field positions
`define SACP_CTRL_START_BIT 3
`define SACP_PRE_HALT_BIT   2
// Reset values
`define SACP_CTRL_LO_RST   4'h0
`define SACP_CTRL_HI_RST   4'h0
`define SACP_RESULT_RST    8'h00
// Timing count and widths
`define SACP_MACH_DIV      3'h6
`define SACP_PRE_WIDTH     12
`define SACP_RES_WIDTH     8
`endif

// file: hw/sacp_sync.v
// Two-flop synchroniser for one level from outside the clock domain
module sacp_sync (
  input  wire i_sys_clk, // System clock
  input  wire i_rst_b,   // Asynchronous reset, active low
  input  wire i_async,   // Level from a pin
  output wire o_sync     // Level safe to use
);
  reg meta_q;  // First stage, read only by the second
  reg sync_q;  // Second stage

  // Plain double register, reset to zero
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;
endmodule // sacp_sync

// file: verification/sacp_adc_ctrl_chk.sv
// Port-level checker for the converter control and prescaler
module sacp_adc_ctrl_chk #(
  parameter int DIV_SEL = 0  // Prescaler tap feeding the pin
) (
  input wire        i_sys_clk,         // Clock
  input wire        i_rst_b,           // Reset, active low
  input wire        i_per_wr,          // Write strobe
  input wire        i_per_rd,          // Read strobe
  input wire [3:0]  i_per_addr,        // Register index
  input wire [3:0]  i_per_wdata,       // Write nibble
  input wire [3:0]  o_per_rdata,       // Read nibble
  input wire [7:0]  o_dac_code,        // Trial code
  input wire [2:0]  o_analog_sel,      // Selected input
  input wire        o_sample,          // Converting
  input wire [11:0] o_pre_taps,        // Prescaler count
  input wire        o_clock_output_pin // Clock output pin
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  ////////////////////////////////////////
  // Request steps
  sequence s_start;
    i_per_wr && i_per_addr == 4'h7 && i_per_wdata[3];
  endsequence
  sequence s_halt;
    i_per_wr && i_per_addr == 4'h3 && i_per_wdata[2];
  endsequence
  sequence s_run;
    i_per_wr && i_per_addr == 4'h3 && !i_per_wdata[2];
  endsequence
  ////////////////////////////////////////
  a_pin_tap: assert property (o_clock_output_pin == o_pre_taps[DIV_SEL])
    else $error("clock pin differs from its tap");
  a_pre_count: assert property ($changed(o_pre_taps) |->
    o_pre_taps == $past(o_pre_taps) + 12'h001 || o_pre_taps == 12'h000)
    else $error("prescaler skipped a count");
  a_pre_halt: assert property (s_halt |-> ##2 (o_pre_taps == 12'h000) [*8])
    else $error("prescaler runs while halted");
  a_pre_restart: assert property (s_run |=> o_pre_taps == 12'h000)
    else $error("prescaler restart not from zero");
  a_start_trial: assert property (s_start |=> o_sample && o_dac_code == 8'h80)
    else $error("start did not begin the first trial");
  a_conv_span: assert property ($rose(o_sample) |-> o_sample [*8])
    else $error("conversion ended too early");
  a_chan_low: assert property (i_per_wr && i_per_addr == 4'h7 |=>
    o_analog_sel[1:0] == $past(i_per_wdata[1:0]))
    else $error("low channel bits not applied");
  a_chan_bank: assert property (i_per_wr && i_per_addr == 4'ha |=>
    o_analog_sel[2] == $past(i_per_wdata[0]))
    else $error("input bank bit not applied");
  a_busy_flag: assert property (i_per_rd && i_per_addr == 4'h7 && o_sample
    |=> !o_per_rdata[3])
    else $error("done shown during conversion");
endmodule // sacp_adc_ctrl_chk
bind sacp_adc_ctrl sacp_adc_ctrl_chk #(.DIV_SEL(DIV_SEL)) u_chk (
  .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_per_wr(i_per_wr),
  .i_per_rd(i_per_rd), .i_per_addr(i_per_addr), .i_per_wdata(i_per_wdata),
  .o_per_rdata(o_per_rdata), .o_dac_code(o_dac_code),
  .o_analog_sel(o_analog_sel), .o_sample(o_sample), .o_pre_taps(o_pre_taps),
  .o_clock_output_pin(o_clock_output_pin));

// file: verification/sacp_cmp_model.sv
// Ideal comparator behind eight analog inputs
module sacp_cmp_model (
  input  wire [63:0] i_levels,    // Eight input levels as codes
  input  wire [2:0]  i_sel,       // Selected input
  input  wire [7:0]  i_dac_code,  // Trial code
  output wire        o_cmp_above  // Level at or above trial
);
  timeunit 1ns;
  timeprecision 1ps;
  // Wrong channel selection shows up as a wrong result
  assign o_cmp_above = i_levels[i_sel*8 +: 8] >= i_dac_code;
endmodule // sacp_cmp_model

// Outside source for the conversion clock pin
module sacp_conv_clk_model #(
  parameter int HALF = 37  // Half period in ns; odd, yet every fourth edge lands on a system clock edge
) (
  output logic o_conv_clk  // Free-running conversion clock
);
  timeunit 1ns;
  timeprecision 1ps;
  // Running from time zero, so it has already toggled once before the first start
  initial o_conv_clk = 1'b0;
  // Far slower than the system clock, standing in for the rate limit
  always #HALF o_conv_clk = ~o_conv_clk;
endmodule // sacp_conv_clk_model

// file: verification/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, rst_b = 0, wr = 0, rd = 0, lsb = 0; // Bench drives
  logic [3:0]  addr = 0, wdata = 0, rdata, q, lo, hi;       // Register port
  logic [3:0]  rdata_x, qx, lox, hix;                       // Pin-clocked copy
  logic [7:0]  dac, dac_x;                                  // Trial codes
  logic [2:0]  sel, sel_x;                                  // Selected inputs
  logic        sample, cmp, pin, sample_x, cmp_x, ext_clk;  // Status lines
  logic [11:0] taps;                                        // Prescaler count
  logic [63:0] lvls = 64'hfe5a_a501_7f80_ff00;              // Row table: level per channel
  int          n, i, failures = 0, checks = 0;              // Loop and counters
  always #4 clk = ~clk;
  sacp_adc_ctrl dut (.i_sys_clk(clk), .i_rst_b(rst_b), .i_per_wr(wr), .i_per_rd(rd),
    .i_per_addr(addr), .i_per_wdata(wdata), .i_index_lsb(lsb), .o_per_rdata(rdata),
    .i_conv_clock_pin(ext_clk), .i_cmp_above(cmp), .o_dac_code(dac), .o_analog_sel(sel),
    .o_sample(sample), .o_pre_taps(taps), .o_clock_output_pin(pin));
  sacp_cmp_model u_cmp (.i_levels(lvls), .i_sel(sel), .i_dac_code(dac), .o_cmp_above(cmp));
  // Second copy takes its conversion clock from the pin, on the same register port
  sacp_adc_ctrl #(.USE_EXT_CLK(1)) dut_ext (.i_sys_clk(clk), .i_rst_b(rst_b), .i_per_wr(wr),
    .i_per_rd(rd), .i_per_addr(addr), .i_per_wdata(wdata), .i_index_lsb(lsb),
    .o_per_rdata(rdata_x), .i_conv_clock_pin(ext_clk), .i_cmp_above(cmp_x),
    .o_dac_code(dac_x), .o_analog_sel(sel_x), .o_sample(sample_x), .o_pre_taps(),
    .o_clock_output_pin());
  sacp_cmp_model u_cmp_x (.i_levels(lvls), .i_sel(sel_x), .i_dac_code(dac_x),
    .o_cmp_above(cmp_x));
  sacp_conv_clk_model u_clk (.o_conv_clk(ext_clk));
  ////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [11:0] e, input logic [11:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  // One-cycle strobes, launched at the falling edge
  task automatic wrt(input logic [3:0] a, input logic [3:0] d);
    @(negedge clk) {wr, addr, wdata} = {1'b1, a, d};
    @(negedge clk) wr = 0;
  endtask
  task automatic rdt(input logic [3:0] a, input logic l, output logic [3:0] r,
                     output logic [3:0] rx);
    @(negedge clk) {rd, addr, lsb} = {1'b1, a, l};
    @(negedge clk) rd = 0;
    r = rdata;
    rx = rdata_x;
  endtask
  // Bounded wait on both copies: a stuck conversion ends the run
  task automatic wait_done();
    for (i = 0; i < 2000 && (sample !== 1'b0 || sample_x !== 1'b0); i++) @(negedge clk);
    if (i == 2000) begin
      failures++;
      finish_test();
    end
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk) rst_b = 1;
    chk(12'h000, {3'h0, sample, dac});
    for (n = 0; n < 8; n++) begin
      wrt(4'ha, {3'h0, n[2]});
      wrt(4'h7, {2'b10, n[1:0]});
      wait_done();
      chk(12'(n), {9'h0, sel});
      chk(12'(n), {9'h0, sel_x});
      rdt(4'h7, 1'b0, q, qx);
      chk(12'h008, {8'h0, q & 4'h8});
      chk(12'h008, {8'h0, qx & 4'h8});
      rdt(4'h8, 1'b0, lo, lox);
      rdt(4'h8, 1'b1, hi, hix);
      chk({4'h0, lvls[n*8 +: 8]}, {4'h0, hi, lo});
      chk({4'h0, lvls[n*8 +: 8]}, {4'h0, hix, lox});
      $display("row %0d done", n);
    end
    // Restart mid-conversion; the bank bit is still set from the last row
    wrt(4'h7, 4'b1001);
    repeat (30) @(negedge clk);
    rdt(4'h7, 1'b0, q, qx);
    chk(12'h000, {8'h0, q & 4'h8});
    chk(12'h000, {8'h0, qx & 4'h8});
    wrt(4'h7, 4'b1010);
    wait_done();
    rdt(4'h8, 1'b0, lo, lox);
    rdt(4'h8, 1'b1, hi, hix);
    chk(12'h05a, {4'h0, hi, lo});
    chk(12'h05a, {4'h0, hix, lox});
    $display("restart test done");
    // Halt the prescaler, then let it run again from zero
    wrt(4'h3, 4'h4);
    repeat (20) @(negedge clk);
    chk(12'h000, taps);
    chk(12'h000, {11'h0, pin});
    rdt(4'h3, 1'b0, q, qx);
    chk(12'h004, {8'h0, q});
    wrt(4'h3, 4'h0);
    chk(12'h000, taps);
    // Six edges hold exactly one machine tick: one step up from zero
    repeat (6) @(negedge clk);
    chk(12'h001, taps);
    $display("prescaler test done");
    // Reset in mid-conversion clears the outputs and the done flag
    wrt(4'h7, 4'b1011);
    repeat (10) @(negedge clk);
    rst_b = 0;
    @(negedge clk) chk(12'h000, {3'h0, sample, dac});
    chk(12'h000, {3'h0, sample_x, dac_x});
    rst_b = 1;
    rdt(4'h7, 1'b0, q, qx);
    chk(12'h000, {8'h0, q});
    chk(12'h000, {8'h0, qx});
    $display("reset test done");
    // Unmapped index reads zero
    rdt(4'h5, 1'b0, q, qx);
    chk(12'h000, {8'h0, q});
    $display("unmapped test done");
    finish_test();
  end
endmodule // tb
